// [pecp_consts.vh]
// Purpose: Constants for the command parser of the programming executive
// Assumes: Plain Verilog-2005, included by bare name
// Notes: Function
// Function
// (R1) Header word: opcode in bits 15:12, length in bits 11:0.
// (R2) Unsupported opcode gets a negative-acknowledge reply, nothing executed.
// (R3) Length counts 16-bit words; exactly that many words are read.
// (R4) Every serial transfer is one 16-bit word.
// (R5) Programmer must give the right length or reception breaks.
// (R6) Two instructions pack as low word, top bytes pair, low word.
// (R7) Odd count: second top byte zero, second low word omitted.
// (R8) No checking of argument data beyond the opcode.
// (R9) Programmer must send valid arguments; bad ones go unnoticed.
// (R10) Block read uses opcode 0x2, length 0x4, returns N instructions.
// (R11) Block read second word is instruction count, at most 32768.
// (R12) Start address: third word low byte on top, fourth word low.
// (R13) Block read returns code data only, always in packed layout.
// (R14) Even count: reply starts 0x1200, totals 2 + 3N/2 words.
// (R15) Odd count: reply totals 4 + 3(N-1)/2, ends zero-extended top byte.
// (R16) Read hitting unimplemented memory resets the executive.
// (R17) Length includes the header; length minus one words follow.
`ifndef PECP_CONSTS_VH
`define PECP_CONSTS_VH
`define PECP_WORD_W     16
`define PECP_OP_HI      15
`define PECP_OP_LO      12
`define PECP_LEN_HI     11
`define PECP_LEN_LO     0
`define PECP_OP_READ    4'h2
`define PECP_LEN_READ   12'h004
`define PECP_SUPPORTED  16'h0ffe
`define PECP_READ_HDR   16'h1200
`define PECP_NACK_OP    4'h1
`define PECP_NACK_CODE  4'h2
`define PECP_NACK_TAIL  16'h0002
`define PECP_ADDR_STEP  24'h000002
`define PECP_ARG_COUNT  2'h0
`define PECP_ARG_ADDRH  2'h1
`define PECP_ARG_ADDRL  2'h2
`define PECP_BIT_LAST   4'hf
`define PECP_FIFO_DEPTH 16
`define PECP_FIFO_AW    4
`endif

// [pecp_fifo.v]
// Purpose: Reply word FIFO between parser and serial shifter
// Assumes: Single clock, synchronous active-low reset
// Notes: Flop storage; out_data is the head entry
`timescale 1ns/100ps
`default_nettype none
module pecp_fifo #(
  parameter W     = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [pecp_parser.v]
// Purpose: Command parser of the programming executive on a 16-bit serial link
// Assumes: Link clock far slower than REF_CLK; code memory answers on REF_CLK
// Notes: Words of other supported commands are passed out on CMD_ ports
`include "pecp_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module pecp_parser #(
  parameter [15:0] SUPPORTED = `PECP_SUPPORTED,
  parameter        DEPTH     = `PECP_FIFO_DEPTH,
  parameter        AW        = `PECP_FIFO_AW
) (
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        LINK_SCK,
  input  wire        LINK_SEL_N,
  input  wire        LINK_SDI,
  output wire        LINK_SDO,
  output reg  [23:0] MEM_ADDR,
  output reg         MEM_RD,
  input  wire [23:0] MEM_RDATA,
  input  wire        MEM_ACK,
  input  wire        MEM_UNIMPL,
  output reg         CMD_WORD_VALID,
  output reg  [3:0]  CMD_OPCODE,
  output reg  [15:0] CMD_WORD,
  output reg         CMD_DONE,
  output reg         EXEC_RESET
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_COLL = 4'h1;
  localparam [3:0] ST_NAK0 = 4'h2;
  localparam [3:0] ST_NAK1 = 4'h3;
  localparam [3:0] ST_RHDR = 4'h4;
  localparam [3:0] ST_RLEN = 4'h5;
  localparam [3:0] ST_FTCH = 4'h6;
  localparam [3:0] ST_WAIT = 4'h7;
  localparam [3:0] ST_LOW1 = 4'h8;
  localparam [3:0] ST_MSB  = 4'h9;
  localparam [3:0] ST_LOW2 = 4'ha;

  // Two-flop synchronisers, third stage only for edge finding
  reg        sck_s1_q, sck_s2_q, sck_s3_q;
  reg        sel_s1_q, sel_s2_q, sel_s3_q;
  reg        sdi_s1_q, sdi_s2_q;
  reg [15:0] rx_sh_q;
  reg [15:0] tx_sh_q;
  reg [3:0]  bit_q;
  reg        rx_stb_q;
  reg [15:0] rx_word_q;
  wire       sck_rise = sck_s2_q & ~sck_s3_q;
  wire       sel_fall = ~sel_s2_q & sel_s3_q;
  wire       tx_load;
  wire       tx_valid;
  wire [15:0] tx_data;
  wire       rsp_ready;
  reg        rsp_valid;
  reg [15:0] rsp_data;

  assign LINK_SDO = tx_sh_q[15];
  assign tx_load  = sel_fall | (~sel_s2_q & sck_rise & (bit_q == `PECP_BIT_LAST));

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
      rx_sh_q  <= 16'h0000;
      tx_sh_q  <= 16'h0000;
      bit_q    <= 4'h0;
      rx_stb_q <= 1'b0;
      rx_word_q <= 16'h0000;
    end else begin
      sck_s1_q <= LINK_SCK;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sel_s1_q <= LINK_SEL_N;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      sdi_s1_q <= LINK_SDI;
      sdi_s2_q <= sdi_s1_q;
      rx_stb_q <= 1'b0;
      if (sel_s2_q) begin
        bit_q <= 4'h0;
      end else if (sck_rise) begin
        // Always whole 16-bit words; partial words die with the select
        rx_sh_q <= {rx_sh_q[14:0], sdi_s2_q}; // R4
        bit_q   <= bit_q + 4'h1;
        if (bit_q == `PECP_BIT_LAST) begin
          rx_stb_q  <= 1'b1;
          rx_word_q <= {rx_sh_q[14:0], sdi_s2_q};
        end
      end
      if (tx_load) begin
        tx_sh_q <= tx_valid ? tx_data : 16'h0000;
      end else if (~sel_s2_q & sck_rise) begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end
    end
  end

  pecp_fifo #(
    .W     (`PECP_WORD_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .in_valid  (rsp_valid),
    .in_ready  (rsp_ready),
    .in_data   (rsp_data),
    .out_valid (tx_valid),
    .out_ready (tx_load),
    .out_data  (tx_data)
  );

  reg [3:0]  st_q, st_d;
  reg [3:0]  op_q;
  reg [11:0] left_q;
  reg [1:0]  arg_q;
  reg [15:0] num_q;
  reg [15:0] rem_q;
  reg [7:0]  addrh_q;
  reg        second_q;
  reg [23:0] ins1_q;
  reg [23:0] ins2_q;
  wire [3:0]  hdr_op  = rx_word_q[`PECP_OP_HI:`PECP_OP_LO]; // R1
  wire [11:0] hdr_len = rx_word_q[`PECP_LEN_HI:`PECP_LEN_LO];
  wire        op_ok   = SUPPORTED[op_q];
  // Reply length in words for N instructions
  wire [15:0] reply_len = 16'h0002 + {num_q[15:1], 1'b0} + {1'b0, num_q[15:1]} // R14
                          + (num_q[0] ? 16'h0002 : 16'h0000); // R15

  always @* begin
    rsp_valid = 1'b0;
    rsp_data  = 16'h0000;
    case (st_q)
      ST_NAK0: begin
        rsp_valid = 1'b1;
        rsp_data  = {`PECP_NACK_OP, `PECP_NACK_CODE, 4'h0, op_q}; // R2
      end
      ST_NAK1: begin
        rsp_valid = 1'b1;
        rsp_data  = `PECP_NACK_TAIL;
      end
      ST_RHDR: begin
        rsp_valid = 1'b1;
        rsp_data  = `PECP_READ_HDR; // R14
      end
      ST_RLEN: begin
        rsp_valid = 1'b1;
        rsp_data  = reply_len;
      end
      ST_LOW1: begin
        rsp_valid = 1'b1;
        rsp_data  = ins1_q[15:0]; // R6
      end
      ST_MSB: begin
        rsp_valid = 1'b1;
        // Second slot is zero when the count is odd
        rsp_data  = {second_q ? ins2_q[23:16] : 8'h00, ins1_q[23:16]}; // R7
      end
      ST_LOW2: begin
        rsp_valid = 1'b1;
        rsp_data  = ins2_q[15:0]; // R6
      end
      default: begin
        rsp_valid = 1'b0;
        rsp_data  = 16'h0000;
      end
    endcase
  end

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (rx_stb_q) begin
        st_d = (hdr_len > 12'h001) ? ST_COLL : (SUPPORTED[hdr_op] ? ST_IDLE : ST_NAK0);
      end
      ST_COLL: if (rx_stb_q && left_q == 12'h001) begin
        // Whole command taken before any reply
        st_d = !op_ok ? ST_NAK0 : (op_q == `PECP_OP_READ) ? ST_RHDR : ST_IDLE; // R3
      end
      ST_NAK0: if (rsp_ready) st_d = ST_NAK1;
      ST_NAK1: if (rsp_ready) st_d = ST_IDLE;
      ST_RHDR: if (rsp_ready) st_d = ST_RLEN;
      ST_RLEN: if (rsp_ready) st_d = (num_q == 16'h0000) ? ST_IDLE : ST_FTCH;
      ST_FTCH: st_d = ST_WAIT;
      ST_WAIT: begin
        if (MEM_UNIMPL) begin
          st_d = ST_IDLE; // R16
        end else if (MEM_ACK) begin
          st_d = second_q ? ST_MSB : ST_LOW1;
        end
      end
      ST_LOW1: if (rsp_ready) st_d = (rem_q == 16'h0000) ? ST_MSB : ST_FTCH; // R15
      ST_MSB: if (rsp_ready) st_d = second_q ? ST_LOW2 : ST_IDLE;
      ST_LOW2: if (rsp_ready) st_d = (rem_q == 16'h0000) ? ST_IDLE : ST_FTCH; // R14
      default: st_d = ST_IDLE;
    endcase
  end

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_q           <= ST_IDLE;
      op_q           <= 4'h0;
      left_q         <= 12'h000;
      arg_q          <= 2'h0;
      num_q          <= 16'h0000;
      rem_q          <= 16'h0000;
      addrh_q        <= 8'h00;
      second_q       <= 1'b0;
      ins1_q         <= 24'h000000;
      ins2_q         <= 24'h000000;
      MEM_ADDR       <= 24'h000000;
      MEM_RD         <= 1'b0;
      CMD_WORD_VALID <= 1'b0;
      CMD_OPCODE     <= 4'h0;
      CMD_WORD       <= 16'h0000;
      CMD_DONE       <= 1'b0;
      EXEC_RESET     <= 1'b0;
    end else begin
      st_q           <= st_d;
      MEM_RD         <= 1'b0;
      CMD_WORD_VALID <= 1'b0;
      CMD_DONE       <= 1'b0;
      EXEC_RESET     <= 1'b0;
      if (st_q == ST_IDLE && rx_stb_q) begin
        op_q       <= hdr_op;
        CMD_OPCODE <= hdr_op;
        left_q     <= hdr_len - 12'h001; // R17
        arg_q      <= `PECP_ARG_COUNT;
        // A length of one means the header alone
        CMD_DONE   <= SUPPORTED[hdr_op] && (hdr_len <= 12'h001) && (hdr_op != `PECP_OP_READ);
      end
      if (st_q == ST_COLL && rx_stb_q) begin
        left_q <= left_q - 12'h001; // R3
        arg_q  <= arg_q + 2'h1;
        // Arguments are passed on unchecked
        CMD_WORD_VALID <= op_ok && (op_q != `PECP_OP_READ); // R8
        CMD_WORD       <= rx_word_q;
        CMD_DONE       <= op_ok && (op_q != `PECP_OP_READ) && (left_q == 12'h001);
        if (op_q == `PECP_OP_READ) begin // R10
          case (arg_q)
            `PECP_ARG_COUNT: num_q <= rx_word_q; // R11
            `PECP_ARG_ADDRH: addrh_q <= rx_word_q[7:0]; // R12
            `PECP_ARG_ADDRL: MEM_ADDR <= {addrh_q, rx_word_q}; // R12
            default: num_q <= num_q;
          endcase
        end
      end
      if (st_q == ST_RHDR) begin
        rem_q    <= num_q;
        second_q <= 1'b0;
      end
      if (st_q == ST_FTCH) begin
        // Code memory only, one 24-bit instruction per fetch
        MEM_RD <= 1'b1; // R13
        rem_q  <= rem_q - 16'h0001;
      end
      if (st_q == ST_WAIT) begin
        if (MEM_UNIMPL) begin
          EXEC_RESET <= 1'b1; // R16
        end else if (MEM_ACK) begin
          MEM_ADDR <= MEM_ADDR + `PECP_ADDR_STEP;
          if (second_q) begin
            ins2_q <= MEM_RDATA;
          end else begin
            ins1_q <= MEM_RDATA;
          end
        end
      end
      if (st_q == ST_LOW1 && rsp_ready && rem_q != 16'h0000) begin
        second_q <= 1'b1;
      end
      if (st_q == ST_LOW2 && rsp_ready) begin
        second_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [pecp_chk_sva.sv]
// Purpose: Port checker for the command parser
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every parser instance
`timescale 1ns/100ps
`default_nettype none
module pecp_chk #(
  parameter [15:0] SUPPORTED = 16'h0ffe
) (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic [23:0] MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        MEM_ACK,
  input wire logic        MEM_UNIMPL,
  input wire logic        CMD_WORD_VALID,
  input wire logic [3:0]  CMD_OPCODE,
  input wire logic        CMD_DONE,
  input wire logic        EXEC_RESET
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  property p_rd_pulse; MEM_RD |=> !MEM_RD; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_rd_op; MEM_RD |-> CMD_OPCODE == 4'h2; endproperty
  a_rd_op: assert property (p_rd_op) else $error("read outside block read");
  property p_addr_hold; MEM_RD && !MEM_ACK |=> $stable(MEM_ADDR); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_nack; !SUPPORTED[CMD_OPCODE] |-> !CMD_WORD_VALID && !CMD_DONE; endproperty
  a_nack: assert property (p_nack) else $error("unsupported opcode executed");
  property p_word_gap; CMD_WORD_VALID |=> !CMD_WORD_VALID [*8]; endproperty
  a_word_gap: assert property (p_word_gap) else $error("word strobe too close");
  property p_unimpl; MEM_UNIMPL |-> ##[1:3] EXEC_RESET; endproperty
  a_unimpl: assert property (p_unimpl) else $error("no executive reset");
  property p_idle; EXEC_RESET |=> !MEM_RD [*4]; endproperty
  a_idle: assert property (p_idle) else $error("read after executive reset");
  property p_exec_pulse; EXEC_RESET |=> !EXEC_RESET; endproperty
  a_exec_pulse: assert property (p_exec_pulse) else $error("reset pulse too long");
endmodule
bind pecp_parser pecp_chk #(.SUPPORTED(SUPPORTED)) u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_ACK(MEM_ACK), .MEM_UNIMPL(MEM_UNIMPL),
  .CMD_WORD_VALID(CMD_WORD_VALID), .CMD_OPCODE(CMD_OPCODE), .CMD_DONE(CMD_DONE),
  .EXEC_RESET(EXEC_RESET));
`default_nettype wire

// [pecp_prog.sv]
// Purpose: Programmer model, link master in mode 0
// Assumes: 200 ns link period
// Notes: Clock stays low outside frames
`timescale 1ns/100ps
`default_nettype none
module pecp_prog (
  output var logic sck,
  output var logic sel_n,
  output var logic sdi,
  input  wire logic sdo
);
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic frame(input logic on);
    #300 sel_n = !on;
    #300;
  endtask
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      #100 sck = 1'b1;
      rx[i] = sdo;
      #100 sck = 1'b0;
    end
    // Spent line shows the inverse, not a stale bit
    sdi = !sdi;
  endtask
endmodule
`default_nettype wire

// [pecp_parser_tb_top.sv]
// Purpose: Self-checking bench for the command parser
// Assumes: Memory answers at falling edges
// Notes: Filler 0xb001 is a header-only command with no reply
`timescale 1ns/100ps
`default_nettype none
module pecp_parser_tb_top;
  logic        ref_clk = 1'b0, rst_n = 1'b0, mem_ack = 1'b0, mem_unimpl = 1'b0;
  logic        sck, sel_n, sdi, sdo, mem_rd, cmd_wv, cmd_done, exec_reset;
  logic [23:0] mem_addr, mem_rdata = 24'h0;
  logic [3:0]  cmd_op;
  logic [15:0] cmd_word, last_word, tx_q[$], exp_q[$];
  int          failures = 0, n_checks = 0, n_words = 0, n_done = 0, n_exec = 0, mem_wait = 0;
  always #12.5 ref_clk = ~ref_clk;
  pecp_parser dut (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK_SCK(sck), .LINK_SEL_N(sel_n),
    .LINK_SDI(sdi), .LINK_SDO(sdo), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
    .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .MEM_UNIMPL(mem_unimpl),
    .CMD_WORD_VALID(cmd_wv), .CMD_OPCODE(cmd_op), .CMD_WORD(cmd_word),
    .CMD_DONE(cmd_done), .EXEC_RESET(exec_reset));
  pecp_prog prog (.sck(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo));
  function automatic logic [23:0] mem_val(input logic [23:0] a);
    return {a[7:0] ^ 8'h3c, a[15:0] ^ 16'h0f0f};
  endfunction
  // Top address bit marks unimplemented memory
  always @(negedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_unimpl <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_rd) begin
      repeat (mem_wait) @(negedge ref_clk);
      mem_ack <= !mem_addr[23];
      mem_unimpl <= mem_addr[23];
      mem_rdata <= mem_val(mem_addr);
    end
  end
  always @(posedge ref_clk) begin
    if (rst_n && cmd_wv) last_word = cmd_word;
    if (rst_n) n_words += cmd_wv;
    if (rst_n) n_done += cmd_done;
    if (rst_n) n_exec += exec_reset;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send();
    logic [15:0] rx;
    prog.frame(1'b1);
    foreach (tx_q[i]) prog.xfer(tx_q[i], rx);
    prog.frame(1'b0);
  endtask
  // Trailing word proves the buffer ran empty
  task automatic expect_reply();
    logic [15:0] rx;
    exp_q.push_back(16'h0000);
    prog.frame(1'b1);
    foreach (exp_q[i]) begin
      prog.xfer(16'hb001, rx);
      check(rx, exp_q[i]);
    end
    prog.frame(1'b0);
  endtask
  task automatic t_cmd();
    int w0 = n_words;
    int d0 = n_done;
    tx_q = '{16'h4003, 16'h2004, 16'h0123};
    send();
    #1000;
    check(n_words - w0, 2);
    check(n_done - d0, 1);
    check(last_word, 16'h0123);
    check(cmd_op, 4'h4);
  endtask
  task automatic t_nack();
    logic [3:0] ops[5] = '{4'h0, 4'hc, 4'hd, 4'he, 4'hf};
    foreach (ops[k]) begin
      tx_q = '{{ops[k], 12'h003}, 16'h1234, 16'h2004};
      exp_q = '{{8'h12, 4'h0, ops[k]}, 16'h0002};
      send();
      #1000;
      expect_reply();
    end
  endtask
  task automatic t_read(input logic [23:0] a, input int n, input int wt);
    logic [23:0] d1, d2;
    mem_wait = wt;
    tx_q = '{16'h2004, n[15:0], {8'h00, a[23:16]}, a[15:0]};
    exp_q = '{16'h1200, 16'((n % 2) ? 4 + 3 * (n - 1) / 2 : 2 + 3 * n / 2)};
    for (int i = 0; i < n && !a[23]; i += 2) begin
      d1 = mem_val(a + 24'(2 * i));
      d2 = (i + 1 < n) ? mem_val(a + 24'(2 * i + 2)) : 24'h0;
      exp_q.push_back(d1[15:0]);
      exp_q.push_back({d2[23:16], d1[23:16]});
      if (i + 1 < n) exp_q.push_back(d2[15:0]);
    end
    send();
    #4000;
    expect_reply();
  endtask
  task automatic t_unimpl();
    int e0 = n_exec;
    t_read(24'h800010, 2, 1);
    check(n_exec - e0, 1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    #500;
    t_cmd();
    t_nack();
    t_read(24'h000100, 4, 0);
    // Zero count: header and length word only
    t_read(24'h000200, 0, 0);
    t_read(24'h012346, 3, 3);
    // Seventeen reply words overfill the buffer
    t_read(24'h00fffe, 10, 1);
    t_unimpl();
    t_cmd();
    report_and_stop();
  end
  initial begin
    #2000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
